// ==== hdl/bdm_pkg.sv ====
// package: constants and carriers for banked data memory addressing
package bdm_pkg;
    localparam int ADDR_W         = 14;
    localparam int BANK_W         = 6;
    localparam int OFS_W          = 8;
    localparam int NUM_BANKS      = 64;
    localparam int BANK_BYTES     = 256;
    localparam int SPACE_BYTES    = 16384;
    localparam logic [7:0] BANK_SEL_RESET    = 8'h00;
    localparam logic [7:0] BANK_SEL_IMPL     = 8'h3F;
    localparam logic [5:0] CTRL_FIRST_BANK   = 6'h38;
    localparam logic [5:0] TOP_BANK          = 6'h3F;
    localparam logic [5:0] ZERO_BANK         = 6'h00;
    localparam logic [7:0] ACCESS_SPLIT      = 8'h60;
    localparam logic [7:0] PC_REG_OFS        = 8'hF9;
    localparam logic [3:0] EXT_WORD_NIBBLE   = 4'hF;
    localparam logic [63:0] BANKS_IMPL_SMALL = 64'hFF00_0000_0000_000F;
    localparam logic [63:0] BANKS_IMPL_LARGE = 64'hFF00_0000_0000_00FF;

    typedef enum logic [1:0] {
        MODE_BANKED,
        MODE_ACCESS,
        MODE_FULL
    } bdm_mode_type;

    typedef struct packed {
        logic               valid;
        bdm_mode_type       mode;
        logic               access_bit;
        logic [OFS_W-1:0]   offset;
        logic [ADDR_W-1:0]  full_addr;
        logic               wr;
        logic [7:0]         wdata;
    } bdm_req_type;

    typedef struct packed {
        logic               valid;
        logic [ADDR_W-1:0]  addr;
        logic               implemented;
        logic               wr_en;
        logic               pc_write;
    } bdm_resp_type;

    typedef enum logic [1:0] {
        EX_NORMAL,
        EX_WORD2,
        EX_WORD3
    } bdm_ext_state_type;
endpackage

// ==== hdl/bdm_addr_unit.sv ====
// banked data memory address generation, bank decode and long-move words
// Summary of operation
// - every data location has a 14-bit byte address, 16384 bytes total
// - address space splits into 64 banks of 256 bytes
// - reads of unimplemented locations return all zeros
// - address is full 14 bits or 8-bit offset plus 6-bit bank selector
// - bank selector gives upper six bits, instruction gives lower eight
// - bank selector keeps six low bits; upper two read zero
// - load bank literal writes its immediate into the bank selector
// - writes to unimplemented banks are dropped, no state changes
// - status flags update as if unimplemented access had succeeded
// - bank 3Fh offset F9h maps to program counter register
// - all locations reachable by direct, indirect and indexed access
// - 256-byte access window reaches bank zero low part and some special registers
// - instruction access bit can override bank selector
// - skipped long move leaves words two and three as no-operations
// - window 00h-5Fh maps to bank zero, 60h-FFh to bank 63
// - access bit zero uses window map, one uses bank selector
// - special function registers occupy banks 56 to 63, 3800h-3FFFh
`timescale 1ns/1ns
module bdm_addr_unit
    import bdm_pkg::*;
#(
    parameter logic [63:0] BANKS_IMPL = BANKS_IMPL_LARGE
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire bdm_req_type  req,
    input  wire logic         load_bank_literal,
    input  wire logic [7:0]   bank_literal,
    input  wire logic         bank_sel_wr,
    input  wire logic         instr_valid,
    input  wire logic [15:0]  instr_word,
    input  wire logic         long_move_three_word,
    input  wire logic         skip_taken,
    input  wire logic [7:0]   mem_rdata,
    input  wire logic [7:0]   alu_result,
    output bdm_resp_type      resp,
    output logic [7:0]        rdata,
    output logic [7:0]        bank_selector,
    output logic              flags_update,
    output logic              zero_flag,
    output logic              ext_word_nop,
    output logic              ext_word_use,
    output logic [11:0]       ext_operand
);
    logic [7:0]         bank_sel_r;
    logic [ADDR_W-1:0]  addr_nxt;
    logic [BANK_W-1:0]  bank_nxt;
    logic               impl_nxt;
    bdm_resp_type       resp_r;
    logic [7:0]         rdata_r;
    logic               flags_r;
    logic               zero_r;
    bdm_ext_state_type  ext_r;
    logic               nop_r;
    logic               use_r;
    logic [11:0]        oper_r;
    logic               ext_word;

    // address formation
    always_comb begin
        addr_nxt = req.full_addr;
        if (req.mode != MODE_FULL) begin
            if (req.mode == MODE_ACCESS && !req.access_bit) begin
                // window: low part of bank zero, top of bank 63
                if (req.offset < ACCESS_SPLIT) begin
                    addr_nxt = {ZERO_BANK, req.offset};
                end else begin
                    addr_nxt = {TOP_BANK, req.offset};
                end
            end else begin
                addr_nxt = {bank_sel_r[5:0], req.offset};
            end
        end
        bank_nxt = addr_nxt[ADDR_W-1:OFS_W];
        impl_nxt = BANKS_IMPL[bank_nxt];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bank_sel_r <= BANK_SEL_RESET;
        end else if (load_bank_literal) begin
            bank_sel_r <= bank_literal & BANK_SEL_IMPL;
        end else if (bank_sel_wr) begin
            bank_sel_r <= req.wdata & BANK_SEL_IMPL;
        end
    end

    // response, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resp_r  <= '0;
            rdata_r <= 8'h00;
        end else begin
            resp_r.valid       <= req.valid;
            resp_r.addr        <= addr_nxt;
            resp_r.implemented <= impl_nxt;
            // dropped write: memory never sees the strobe
            resp_r.wr_en    <= req.valid && req.wr && impl_nxt;
            resp_r.pc_write <= req.valid && req.wr && impl_nxt
                && addr_nxt == {TOP_BANK, PC_REG_OFS};
            rdata_r <= impl_nxt ? mem_rdata : 8'h00;
        end
    end

    // flags follow the alu even when the bank is not there
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flags_r <= 1'b0;
            zero_r  <= 1'b0;
        end else begin
            flags_r <= req.valid;
            zero_r  <= req.valid ? (alu_result == 8'h00) : zero_r;
        end
    end

    assign ext_word = instr_word[15:12] == EXT_WORD_NIBBLE;

    // long move tracker: trailing words only count right after word one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_r  <= EX_NORMAL;
            nop_r  <= 1'b0;
            use_r  <= 1'b0;
            oper_r <= 12'h000;
        end else if (instr_valid) begin
            nop_r <= 1'b0;
            use_r <= 1'b0;
            case (ext_r)
                EX_NORMAL: begin
                    if (skip_taken) begin
                        ext_r <= EX_NORMAL;
                        nop_r <= ext_word;
                    end else if (long_move_three_word) begin
                        ext_r <= EX_WORD2;
                    end else begin
                        nop_r <= ext_word;
                    end
                end
                EX_WORD2: begin
                    use_r  <= ext_word;
                    oper_r <= instr_word[11:0];
                    ext_r  <= ext_word ? EX_WORD3 : EX_NORMAL;
                end
                EX_WORD3: begin
                    use_r  <= ext_word;
                    oper_r <= instr_word[11:0];
                    ext_r  <= EX_NORMAL;
                end
                default: begin
                    ext_r <= EX_NORMAL;
                end
            endcase
        end else begin
            nop_r <= 1'b0;
            use_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resp          <= '0;
            rdata         <= 8'h00;
            bank_selector <= 8'h00;
            flags_update  <= 1'b0;
            zero_flag     <= 1'b0;
            ext_word_nop  <= 1'b0;
            ext_word_use  <= 1'b0;
            ext_operand   <= 12'h000;
        end else begin
            resp          <= resp_r;
            rdata         <= rdata_r;
            bank_selector <= bank_sel_r;
            flags_update  <= flags_r;
            zero_flag     <= zero_r;
            ext_word_nop  <= nop_r;
            ext_word_use  <= use_r;
            ext_operand   <= oper_r;
        end
    end

    property p_upper_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        bank_selector[7:6] == 2'b00;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("bank selector upper bits not zero");

    property p_literal_load;
        @(posedge ref_clk) disable iff (!rst_n)
        load_bank_literal |=> ##1 bank_selector == ($past(bank_literal, 2)
            & BANK_SEL_IMPL);
    endproperty
    a_literal_load: assert property (p_literal_load)
        else $error("literal not loaded into bank selector");

    property p_unimpl_read;
        @(posedge ref_clk) disable iff (!rst_n)
        resp_r.valid && !resp_r.implemented |=> rdata == 8'h00;
    endproperty
    a_unimpl_read: assert property (p_unimpl_read)
        else $error("unimplemented read not zero");

    property p_unimpl_write;
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && req.wr && !impl_nxt |-> ##2 !resp.wr_en;
    endproperty
    a_unimpl_write: assert property (p_unimpl_write)
        else $error("write to unimplemented bank passed");

    property p_flags;
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid |-> ##2 flags_update;
    endproperty
    a_flags: assert property (p_flags)
        else $error("flags not updated");

    property p_window_low;
        @(posedge ref_clk) disable iff (!rst_n)
        req.mode == MODE_ACCESS && !req.access_bit && req.offset < ACCESS_SPLIT
        |-> ##1 resp_r.addr[13:8] == ZERO_BANK;
    endproperty
    a_window_low: assert property (p_window_low)
        else $error("window low half misrouted");

    property p_banked;
        @(posedge ref_clk) disable iff (!rst_n)
        req.mode == MODE_BANKED
            || (req.mode == MODE_ACCESS && req.access_bit)
        |-> ##1 resp_r.addr == {$past(bank_sel_r[5:0]), $past(req.offset)};
    endproperty
    a_banked: assert property (p_banked)
        else $error("banked address wrong");

    property p_window_high;
        @(posedge ref_clk) disable iff (!rst_n)
        req.mode == MODE_ACCESS && !req.access_bit
            && req.offset >= ACCESS_SPLIT
        |-> ##1 resp_r.addr[13:8] == TOP_BANK;
    endproperty
    a_window_high: assert property (p_window_high)
        else $error("window high half misrouted");

    property p_full_addr;
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && req.mode == MODE_FULL
        |-> ##2 resp.addr == $past(req.full_addr, 2);
    endproperty
    a_full_addr: assert property (p_full_addr)
        else $error("full address not passed through");

    // bank 63 exists in every variant, so no implemented term is needed
    property p_pc_write;
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && req.wr && req.mode == MODE_BANKED
            && bank_sel_r[5:0] == TOP_BANK && req.offset == PC_REG_OFS
        |-> ##2 resp.pc_write;
    endproperty
    a_pc_write: assert property (p_pc_write)
        else $error("program counter write not flagged");

    property p_zero_flag;
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid |-> ##2 zero_flag == ($past(alu_result, 2) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero flag does not follow alu");

    property p_selector_write;
        @(posedge ref_clk) disable iff (!rst_n)
        bank_sel_wr && !load_bank_literal
        |=> ##1 bank_selector == ($past(req.wdata, 2) & BANK_SEL_IMPL);
    endproperty
    a_selector_write: assert property (p_selector_write)
        else $error("data write not loaded into bank selector");

    property p_ctrl_banks;
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && req.mode == MODE_FULL
            && req.full_addr[13:8] >= CTRL_FIRST_BANK
        |-> ##2 resp.implemented;
    endproperty
    a_ctrl_banks: assert property (p_ctrl_banks)
        else $error("special register bank not implemented");

    // a trailing word carries operands only right after an executed word one
    sequence s_first_skipped;
        instr_valid && ext_r == EX_NORMAL && skip_taken
            && long_move_three_word;
    endsequence
    sequence s_first_run;
        instr_valid && ext_r == EX_NORMAL && !skip_taken
            && long_move_three_word;
    endsequence
    sequence s_ext_word;
        instr_valid && ext_word;
    endsequence
    property p_skip_nop;
        @(posedge ref_clk) disable iff (!rst_n)
        s_first_skipped ##1 s_ext_word |-> ##2 ext_word_nop && !ext_word_use;
    endproperty
    a_skip_nop: assert property (p_skip_nop)
        else $error("skipped extension word not a nop");

    property p_ext_use;
        @(posedge ref_clk) disable iff (!rst_n)
        s_first_run ##1 s_ext_word |-> ##2 ext_word_use && !ext_word_nop
            && {EXT_WORD_NIBBLE, ext_operand} == $past(instr_word, 2);
    endproperty
    a_ext_use: assert property (p_ext_use)
        else $error("extension word operand not used");
endmodule

// ==== verification/bdm_cpu_model.sv ====
// cpu side model: memory read data and alu result for each request
`timescale 1ns/1ns
module bdm_cpu_model
    import bdm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire bdm_req_type req,
    output logic [7:0]       mem_rdata,
    output logic [7:0]       alu_result
);
    logic [7:0] churn_r = 8'h00;
    // idle data churns so a stale byte never passes for a read
    always @(posedge ref_clk) begin
        churn_r <= churn_r + 8'h35;
    end
    assign mem_rdata  = req.valid ? (req.offset ^ 8'h5A) : churn_r;
    assign alu_result = req.valid ? req.wdata : ~churn_r;
endmodule

// ==== verification/banked_data_memory_addressing_bench.sv ====
// testbench for banked data memory addressing
`timescale 1ns/1ns
module banked_data_memory_addressing_bench
    import bdm_pkg::*;
;
    logic         ref_clk = 1'b0;
    logic         rst_n;
    bdm_req_type  r;
    logic         lbl, bsw, iv, lm, sk;
    logic [7:0]   lit;
    logic [15:0]  iw;
    wire  [7:0]   mem_rdata, alu_result;
    bdm_resp_type resp;
    logic [7:0]   rdata, bsel;
    logic         fl_up, zf, nop, use_w;
    logic [11:0]  eop, last_op;
    int           n_fail, samples_checked, cycles, n_use, n_nop;

    bdm_addr_unit uut (.ref_clk(ref_clk), .rst_n(rst_n), .req(r),
        .load_bank_literal(lbl), .bank_literal(lit), .bank_sel_wr(bsw),
        .instr_valid(iv), .instr_word(iw), .long_move_three_word(lm),
        .skip_taken(sk), .mem_rdata(mem_rdata), .alu_result(alu_result),
        .resp(resp), .rdata(rdata), .bank_selector(bsel),
        .flags_update(fl_up), .zero_flag(zf), .ext_word_nop(nop),
        .ext_word_use(use_w), .ext_operand(eop));
    bdm_cpu_model cpu (.ref_clk(ref_clk), .req(r), .mem_rdata(mem_rdata),
        .alu_result(alu_result));

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (use_w === 1'b1) begin
            n_use++;
            last_op = eop;
        end
        if (nop === 1'b1) n_nop++;
        // generous ceiling: the whole run needs well under 200 cycles
        if (cycles == 3000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic access(input bdm_mode_type m, input logic a,
                          input logic [13:0] f, input logic w);
        r = '{1'b1, m, a, f[7:0], f, w, {2'b00, f[13:8]}};
        @(negedge ref_clk);
        r = '0;
        @(negedge ref_clk);
    endtask
    task automatic load(input logic l, b, input logic [7:0] v);
        lbl = l; bsw = b; lit = v; r.wdata = v ^ 8'hFD;
        @(negedge ref_clk);
        lbl = 0; bsw = 0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic t_bank_sel();
        check("bank_sel reset", bsel, 8'h00);
        load(1, 0, 8'hFF);
        check("bank_sel literal", bsel, 8'h3F);
        load(0, 1, 8'h38);
        check("bank_sel write", bsel, 8'h05);
        load(1, 1, 8'h02);
        check("bank_sel both", bsel, 8'h02);
        load(1, 0, 8'h3F);
    endtask
    task automatic t_banked();
        access(MODE_BANKED, 1'b0, 14'h00F9, 1'b1);
        check("banked addr", resp.addr, 14'h3FF9);
        check("resp valid", resp.valid, 1'b1);
        check("pc write", resp.pc_write, 1'b1);
        check("banked rdata", rdata, 8'hA3);
        access(MODE_ACCESS, 1'b1, 14'h0010, 1'b0);
        check("selector path addr", resp.addr, 14'h3F10);
        check("no pc write", resp.pc_write, 1'b0);
    endtask
    task automatic t_window();
        logic [7:0] ofs [4] = '{8'h00, 8'h5F, 8'h60, 8'hFF};
        foreach (ofs[i]) begin
            access(MODE_ACCESS, 1'b0, {6'h00, ofs[i]}, 1'b0);
            check("window addr", resp.addr,
                  {(ofs[i] < 8'h60) ? 6'h00 : 6'h3F, ofs[i]});
            check("zero flag", zf, 1'b1);
        end
    endtask
    task automatic t_unimpl();
        logic [13:0] fa [5] = '{14'h0800, 14'h07C4, 14'h37FF,
                                14'h3800, 14'h2A11};
        logic        im;
        foreach (fa[i]) begin
            im = BANKS_IMPL_LARGE[fa[i][13:8]];
            access(MODE_FULL, 1'b0, fa[i], 1'b1);
            check("full addr", resp.addr, fa[i]);
            check("implemented", resp.implemented, im);
            check("write enable", resp.wr_en, im);
            check("rdata", rdata, im ? fa[i][7:0] ^ 8'h5A : 8'h00);
            check("flags", fl_up, 1'b1);
            check("zero flag", zf, 1'b0);
        end
    endtask
    task automatic t_long(input logic skip);
        n_use = 0; n_nop = 0;
        iv = 1; iw = 16'h0060; lm = 1; sk = skip;
        @(negedge ref_clk);
        iw = 16'hF48C; lm = 0; sk = 0;
        @(negedge ref_clk);
        iw = 16'hF456;
        @(negedge ref_clk);
        iv = 0; iw = 16'h2400;
        repeat (4) @(negedge ref_clk);
        check("ext use count", n_use, skip ? 0 : 2);
        check("ext nop count", n_nop, skip ? 2 : 0);
        if (!skip) check("ext operand", last_op, 12'h456);
    endtask

    initial begin
        rst_n = 0; r = '0; lbl = 0; bsw = 0; iv = 0; lm = 0; sk = 0;
        lit = 8'h00; iw = 16'h0000; last_op = 12'h000;
        n_fail = 0; samples_checked = 0; cycles = 0;
        repeat (6) @(negedge ref_clk);
        rst_n = 1;
        @(negedge ref_clk);
        t_bank_sel();
        t_banked();
        t_window();
        t_unimpl();
        t_long(1'b0);
        t_long(1'b1);
        final_report();
    end
endmodule
